// ==== common/swire_defs.svh ====
// timing constants and command codes for the single-wire bus master
`ifndef SWIRE_DEFS_SVH
`define SWIRE_DEFS_SVH

`define CLK_MHZ 10
`define T_RST_US 480
`define T_PDLY_MAX_US 60
`define T_PRES_MAX_US 240
`define T_SLOT_US 60
`define T_REC_US 1
`define T_W1_LOW_US 15
`define T_INIT_US 1
`define T_RD_VALID_US 15
`define T_RD_SAMPLE_US 13
`define CYC_RST (`T_RST_US * `CLK_MHZ)
`define CYC_PRES_WIN ((`T_PDLY_MAX_US + `T_PRES_MAX_US) * `CLK_MHZ)
`define CYC_SLOT (`T_SLOT_US * `CLK_MHZ)
`define CYC_REC (`T_REC_US * `CLK_MHZ)
`define CYC_W1_LOW (`T_INIT_US * `CLK_MHZ)
`define CYC_INIT (`T_INIT_US * `CLK_MHZ)
`define CYC_RD_SAMPLE (`T_RD_SAMPLE_US * `CLK_MHZ)
`define CMD_SELECT_LOC 8'h70
`define LOC_MASK 8'h3f

`endif

// ==== common/swire_pkg.sv ====
// types for the single-wire bus master
package swire_pkg;
	typedef enum logic [1:0] {
		OP_RESET,
		OP_WRITE,
		OP_READ,
		OP_SELECT
	} op_type;

	typedef struct packed {
		op_type op;
		logic [7:0] data;
		logic [3:0] nbits;
	} req_type;

	typedef struct packed {
		logic [7:0] data;
		logic presence;
	} rsp_type;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RST_LOW,
		ST_RST_WAIT,
		ST_SLOT,
		ST_REC,
		ST_SEL2
	} state_type;

	typedef struct packed {
		state_type st;
		logic [12:0] cnt;
		logic [7:0] shreg;
		logic [7:0] rdata;
		logic [3:0] left;
		logic [3:0] pos;
		logic rd;
		logic busy;
		logic done;
		logic pres;
		logic dq_oe;
		logic seen_low;
		logic sel;
	} ctl_type;
endpackage : swire_pkg

// ==== design/slot_timer.sv ====
// slot timer: counts cycles within a slot or pulse and flags the end
`timescale 1ns/10ps
`default_nettype none
module slot_timer #(
	parameter int W = 13
) (
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic i_start,
	input wire logic [W-1:0] i_len,
	output logic [W-1:0] o_count,
	output logic o_expired
);
	logic [W-1:0] cnt_q;
	logic run_q;

	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			cnt_q <= '0;
			run_q <= 1'b0;
		end else if (i_start) begin
			cnt_q <= '0;
			run_q <= 1'b1;
		end else if (run_q) begin
			cnt_q <= cnt_q + W'(1);
			if (cnt_q + W'(1) >= i_len) begin
				run_q <= 1'b0;
			end
		end
	end

	assign o_count = cnt_q;
	assign o_expired = run_q && (cnt_q + W'(1) >= i_len);
endmodule : slot_timer
`default_nettype wire

// ==== design/swire_master.sv ====
// single-wire bus master: reset/presence, write and read slots, location select
`timescale 1ns/10ps
`default_nettype none
`include "swire_defs.svh"
module swire_master
	import swire_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic i_req_valid,
	input wire req_type i_req,
	input wire logic i_dq,
	output logic o_dq,
	output logic o_dq_oe,
	output logic o_busy,
	output logic o_done,
	output rsp_type o_rsp
);
	ctl_type q, d;
	logic tstart;
	logic [12:0] tlen;
	logic [12:0] tcount;
	logic texp;
	logic [3:0] nb;

	////////////////////////////////////////////////////////////////////////////
	slot_timer #(
		.W(13)
	) u_timer (
		.i_mclk(i_mclk),
		.i_nrst(i_nrst),
		.i_start(tstart),
		.i_len(tlen),
		.o_count(tcount),
		.o_expired(texp)
	);

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		d = q;
		d.done = 1'b0;
		tstart = 1'b0;
		tlen = 13'(`CYC_SLOT);
		nb = (i_req.nbits == 4'h0 || i_req.nbits > 4'h8) ? 4'h8 : i_req.nbits;
		case (q.st)
			ST_IDLE: begin
				if (i_req_valid) begin
					d.busy = 1'b1;
					d.rdata = 8'h00;
					d.pos = 4'h0;
					d.sel = 1'b0;
					tstart = 1'b1;
					case (i_req.op)
						OP_RESET: begin
							d.st = ST_RST_LOW;
							d.dq_oe = 1'b1;
							tlen = 13'(`CYC_RST);
						end
						OP_SELECT: begin
							// only safe while every device on the bus has its own location
							d.st = ST_SEL2;
							d.sel = 1'b1;
							d.rd = 1'b0;
							d.shreg = `CMD_SELECT_LOC;
							d.rdata = i_req.data & `LOC_MASK;
							d.left = 4'h8;
							d.dq_oe = 1'b1;
						end
						OP_READ: begin
							d.st = ST_SLOT;
							d.rd = 1'b1;
							d.left = nb;
							d.dq_oe = 1'b1;
						end
						default: begin
							d.st = ST_SLOT;
							d.rd = 1'b0;
							d.shreg = i_req.data;
							d.left = nb;
							d.dq_oe = 1'b1;
						end
					endcase
				end
			end
			ST_RST_LOW: begin
				tlen = 13'(`CYC_RST);
				if (texp) begin
					d.dq_oe = 1'b0;
					d.st = ST_RST_WAIT;
					d.seen_low = 1'b0;
					tstart = 1'b1;
				end
			end
			ST_RST_WAIT: begin
				tlen = 13'(`CYC_PRES_WIN);
				if (tcount > 13'(`CYC_REC) && !i_dq) begin
					d.seen_low = 1'b1;
				end
				// a line still held low at the window end must not hang the op
				if (texp) begin
					d.pres = q.seen_low;
					d.busy = 1'b0;
					d.done = 1'b1;
					d.st = ST_IDLE;
				end
			end
			ST_SLOT, ST_SEL2: begin
				// the low pulse, then release for one or read, hold for zero
				if (tcount == 13'(`CYC_INIT) - 13'd1) begin
					if (q.rd || q.shreg[0]) begin
						d.dq_oe = 1'b0;
					end
				end
				if (q.rd && tcount == 13'(`CYC_RD_SAMPLE)) begin
					d.rdata[q.pos[2:0]] = i_dq;
				end
				if (texp) begin
					d.dq_oe = 1'b0;
					d.shreg = {1'b0, q.shreg[7:1]};
					d.pos = q.pos + 4'h1;
					d.left = q.left - 4'h1;
					d.st = ST_REC;
					tstart = 1'b1;
				end
			end
			ST_REC: begin
				tlen = 13'(`CYC_REC);
				if (texp) begin
					if (q.left != 4'h0) begin
						d.st = q.sel ? ST_SEL2 : ST_SLOT;
						d.dq_oe = 1'b1;
						tstart = 1'b1;
					end else if (q.sel) begin
						// command byte sent: follow it with the masked location byte
						d.sel = 1'b0;
						d.shreg = q.rdata;
						d.left = 4'h8;
						d.st = ST_SLOT;
						d.dq_oe = 1'b1;
						tstart = 1'b1;
					end else begin
						d.busy = 1'b0;
						d.done = 1'b1;
						d.st = ST_IDLE;
					end
				end
			end
			default: begin
				d.st = ST_IDLE;
				d.dq_oe = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign o_dq = 1'b0;
	assign o_dq_oe = q.dq_oe;
	assign o_busy = q.busy;
	assign o_done = q.done;
	assign o_rsp = '{data: q.rdata, presence: q.pres};

	////////////////////////////////////////////////////////////////////////////
	a_reset_low_len: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		$rose(q.st == ST_RST_LOW) |-> q.dq_oe [*8])
		else $error("reset pulse released too early");
	a_reset_low_cyc: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		(q.st == ST_RST_WAIT && $past(q.st) == ST_RST_LOW)
		|-> $past(tcount) >= 13'(`CYC_RST) - 13'd1)
		else $error("reset pulse shorter than its count");
	a_presence_rel: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		q.st == ST_RST_WAIT |-> !q.dq_oe)
		else $error("bus driven while listening for presence");
	a_one_slot_bit: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		(q.st == ST_REC && $past(q.st) != ST_REC) |-> q.left == $past(q.left) - 4'h1)
		else $error("slot did not consume one bit");
	a_rec_released: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		q.st == ST_REC |-> !q.dq_oe)
		else $error("bus driven during recovery");
	a_write_one_rel: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		$rose(q.dq_oe) && (q.st == ST_SLOT || q.st == ST_SEL2) && !q.rd && q.shreg[0]
		|-> ##[1:150] !q.dq_oe)
		else $error("write one held too long");
	a_read_release: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		$rose(q.dq_oe) && q.st == ST_SLOT && q.rd |-> ##[1:20] !q.dq_oe)
		else $error("read slot initiation too long");
	a_read_init_min: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		$fell(q.dq_oe) && q.st == ST_SLOT && q.rd |-> $past(tcount) >= 13'(`CYC_INIT) - 13'd1)
		else $error("read slot initiating low too short");
	a_idle_released: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		q.st == ST_IDLE |-> !q.dq_oe)
		else $error("bus driven while idle");
	a_sel_mask: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		q.st == ST_SEL2 |-> q.rdata[7:6] == 2'b00)
		else $error("location byte upper bits set");
	a_sel_addr_hi: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		$rose(q.dq_oe) && q.st == ST_SLOT && q.pos[3:1] == 3'b111 |-> !q.shreg[0])
		else $error("location byte upper bits sent as one");
	a_done_pulse: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		o_done |=> !o_done)
		else $error("done longer than one cycle");
	c_reset: cover property (@(posedge i_mclk) q.st == ST_RST_WAIT ##1 q.st == ST_IDLE);
	c_read: cover property (@(posedge i_mclk) q.rd && q.st == ST_REC && q.left == 4'h0);
	c_select: cover property (@(posedge i_mclk) q.st == ST_SEL2);
	c_write: cover property (@(posedge i_mclk) !q.rd && !q.sel && q.st == ST_REC && q.left == 4'h0);
endmodule : swire_master
`default_nettype wire

// ==== tb/swire_dev.sv ====
// behavioural sensor model on the shared line
`timescale 1ns/10ps
`default_nettype none
module swire_dev (
	input wire logic i_dq,
	input wire logic i_present,
	input wire logic i_rd,
	input wire logic [7:0] i_tx,
	output logic o_oe,
	output logic [7:0] o_rx,
	output logic [7:0] o_loc
);
	realtime t0 = 0;
	logic [7:0] sh = 8'h00;
	int k = 0;
	initial o_oe = 1'b0;
	initial o_rx = 8'h00;
	initial o_loc = 8'h00;
	always @(negedge i_dq) t0 = $realtime;
	////////////////////////////////////////////////////////////////
	always @(posedge i_dq) begin
		if ($realtime - t0 >= 480000) begin
			k = 0;
			#30000 o_oe = i_present;
			#120000 o_oe = 1'b0;
		end
	end
	////////////////////////////////////////////////////////////////
	always @(negedge i_dq) begin
		if (!o_oe) begin
			if (i_rd) begin
				o_oe = !i_tx[k[2:0]];
				#15000 o_oe = 1'b0;
			end else begin
				#30000 sh = {i_dq, sh[7:1]};
			end
			k++;
			// keep the first whole byte after reset, then the location byte
			if (k == 8 && !i_rd) o_rx = sh;
			if (k == 16 && !i_rd) o_loc = sh;
		end
	end
endmodule : swire_dev
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench for the single-wire bus master
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("BAD %s exp %0h got %0h", nm, e, g); end end
module testbench;
	import swire_pkg::*;
	logic i_mclk = 1'b0;
	logic i_nrst = 1'b0;
	logic i_req_valid = 1'b0;
	req_type i_req = '0;
	logic o_dq, o_dq_oe, o_busy, o_done, dev_oe, prev = 1'b0, present = 1'b1, rd = 1'b0;
	rsp_type o_rsp;
	logic [7:0] tx = 8'h00;
	logic [7:0] rx;
	logic [7:0] loc;
	wire logic dq = o_dq_oe ? o_dq : (dev_oe ? 1'b0 : 1'b1);
	int n_errors = 0, total_checks = 0, run = 0;
	int lows[$];
	int highs[$];
	always #50 i_mclk = ~i_mclk;
	swire_master uut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_req_valid(i_req_valid),
		.i_req(i_req), .i_dq(dq), .o_dq(o_dq), .o_dq_oe(o_dq_oe), .o_busy(o_busy),
		.o_done(o_done), .o_rsp(o_rsp));
	swire_dev dev (.i_dq(dq), .i_present(present), .i_rd(rd), .i_tx(tx), .o_oe(dev_oe),
		.o_rx(rx), .o_loc(loc));
	// lengths of driven-low and released runs on the line
	always @(posedge i_mclk) begin
		if (o_dq_oe !== prev) begin
			if (prev) lows.push_back(run);
			else highs.push_back(run);
			run = 0;
		end
		run++;
		prev = o_dq_oe;
	end
	////////////////////////////////////////////////////////////////
	task automatic do_op(input op_type op, input logic [7:0] d, input logic [3:0] n);
		int w;
		@(negedge i_mclk);
		i_req = '{op: op, data: d, nbits: n};
		i_req_valid = 1'b1;
		lows.delete();
		highs.delete();
		@(negedge i_mclk);
		i_req_valid = 1'b0;
		w = 0;
		while (o_done !== 1'b1 && w < 20000) begin
			@(negedge i_mclk);
			w++;
		end
		`CHK("done", 1'b1, o_done)
	endtask : do_op
	task automatic t_reset(input logic p);
		present = p;
		do_op(OP_RESET, 8'h00, 4'h0);
		`CHK("presence", p, o_rsp.presence)
		`CHK("rst_low", 1'b1, lows[0] >= 4800)
	endtask : t_reset
	task automatic t_write(input logic [7:0] d);
		t_reset(1'b1);
		do_op(OP_WRITE, d, 4'h8);
		`CHK("wr_byte", d, rx)
		`CHK("wr_slots", 8, lows.size())
		for (int i = 0; i < 8; i++) begin
			`CHK("wr_low", 1'b1, d[i] ? lows[i] <= 150 : lows[i] >= 600)
			`CHK("wr_rec", 1'b1, highs[i] >= 10)
			`CHK("wr_len", 1'b1, i == 7 || lows[i] + highs[i+1] >= 600)
		end
	endtask : t_write
	task automatic t_read(input logic [7:0] d, input logic [3:0] n);
		t_reset(1'b1);
		tx = d;
		rd = 1'b1;
		do_op(OP_READ, 8'h00, n);
		rd = 1'b0;
		`CHK("rd_data", d & ~(8'hff << n), o_rsp.data)
		`CHK("rd_slots", int'(n), lows.size())
		for (int i = 0; i < n; i++) begin
			`CHK("rd_init", 1'b1, lows[i] >= 10 && lows[i] <= 150)
		end
	endtask : t_read
	task automatic t_select();
		t_reset(1'b1);
		do_op(OP_SELECT, 8'hea, 4'h8);
		`CHK("sel_cmd", 8'h70, rx)
		`CHK("sel_loc", 8'h2a, loc)
		`CHK("sel_rsp", 8'h2a, o_rsp.data)
		`CHK("sel_slots", 16, lows.size())
	endtask : t_select
	task automatic t_midreset();
		@(negedge i_mclk);
		i_req = '{op: OP_WRITE, data: 8'h00, nbits: 4'h8};
		i_req_valid = 1'b1;
		@(negedge i_mclk);
		i_req_valid = 1'b0;
		repeat (400) @(negedge i_mclk);
		`CHK("mid_busy", 1'b1, o_busy)
		`CHK("mid_drive", 1'b1, o_dq_oe)
		i_nrst = 1'b0;
		repeat (2) @(negedge i_mclk);
		`CHK("mid_oe", 1'b0, o_dq_oe)
		i_nrst = 1'b1;
		@(negedge i_mclk);
		`CHK("mid_idle", 1'b0, o_busy)
		`CHK("mid_rsp", 9'h000, o_rsp)
		t_reset(1'b1);
	endtask : t_midreset
	task automatic summarize();
		if (n_errors == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : summarize
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(negedge i_mclk);
		i_nrst = 1'b1;
		t_reset(1'b0);
		t_write(8'ha5);
		t_read(8'hc5, 4'h8);
		t_read(8'h5c, 4'h4);
		t_midreset();
		t_select();
		summarize();
	end
	initial begin
		#9000000;
		n_errors++;
		summarize();
	end
endmodule : testbench
`default_nettype wire
